// *** logic/sdc_adc_ctrl.sv ***
// Sigma-delta converter control: register slave, sample divider, comb decimator and interrupt.
// Operation
// RULE1 - Filter input select picks one of eight sources by its three-bit code.
// RULE2 - Positive path bit 2 turns the input low-pass filter on or off.
// RULE3 - Low two positive path bits pick filtered, unfiltered, input 2 or input 3.
// RULE4 - Negative input select picks input 1, 2, 3 or low temperature node.
// RULE5 - Gain select sets two thirds, one, two or seven thirds.
// RULE6 - Reference enable powers the two tapped reference nodes.
// RULE7 - Positive reference select picks input 0, input 3, upper or lower tap.
// RULE8 - Negative reference select picks ground, input 1, input 2 or lower tap.
// RULE9 - Output rate code divides sample rate by 125 up to 8000; code 7 as 6.
// RULE10 - Sample rate is system clock over 25, or over 50 when divider bit set.
// RULE11 - Interrupt reaches the CPU only with both its enable and global enable set.
// RULE12 - Modulator enable bit switches the modulator on; clear keeps it off.
// RULE13 - Comb run bit enables the decimating comb filter.
// RULE14 - Software reads a 16-bit result high and low; top two bits are sign.
// RULE15 - Modulator bit density tracks input difference over reference difference.
// RULE16 - Comb filter decimates the bitstream into a result of 14-bit precision.
// RULE17 - Auto-zero shorts the positive and negative converter inputs together.
// RULE18 - Clearing auto-zero reconnects the selected inputs for normal measurement.
// RULE19 - One signed result and one interrupt every N samples once enabled.
// RULE20 - Result saturates at plus or minus 15625.
// RULE21 - Software discards the first two results after any input change.
// RULE22 - Conversion flag sets on each result load and holds until software clears.
// RULE23 - While comb run is clear the comb accumulators are held cleared.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
module sdc_adc_ctrl
	import sdc_pkg::*;
(
	input  wire logic          REF_CLK,
	input  wire logic          RESET,
	input  wire logic          WB_CYC_I,
	input  wire logic          WB_STB_I,
	input  wire logic          WB_WE_I,
	input  wire logic [7:0]    WB_ADR_I,
	input  wire logic [3:0]    WB_SEL_I,
	input  wire logic [31:0]   WB_DAT_I,
	output logic      [31:0]   WB_DAT_O,
	output logic               WB_ACK_O,
	input  wire logic          MODULATOR_BIT,
	output logic               SAMPLE_STROBE,
	output sdc_ana_ctrl_s      ANALOG_CTRL,
	output logic               CONVERSION_IRQ
);
	logic [7:0]  input_routing;
	logic [7:0]  reference_routing;
	logic [7:0]  gain_and_enable;
	logic [7:0]  converter_control;
	logic        sample_divider_select;
	logic        conversion_irq_flag;
	logic        conversion_irq_enable;
	logic        global_irq_enable;
	logic [15:0] conversion_result;
	logic [5:0]  div_cnt;
	logic        mod_sync1;
	logic        mod_sync2;
	logic [13:0] samp_cnt;
	logic [13:0] ones_cur;
	logic [13:0] ones_prev;

	// Bus decode: one access per request, answered with ack in the following cycle.
	wire        req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire [5:0]  idx       = WB_ADR_I[7:2];
	wire        wr        = req & WB_WE_I & WB_SEL_I[0];
	wire [7:0]  wd        = WB_DAT_I[7:0];
	wire        wr_flags  = wr && idx == IDX_IRQ_FLAGS;
	wire        wr_enab   = wr && idx == IDX_IRQ_ENABLES;
	wire        wr_ctrl   = wr && idx == IDX_CONV_CTRL;
	wire        wr_sclk   = wr && idx == IDX_SAMPLE_CLOCK;
	wire        wr_inrt   = wr && idx == IDX_INPUT_ROUTING;
	wire        wr_refrt  = wr && idx == IDX_REF_ROUTING;
	wire        wr_gain   = wr && idx == IDX_GAIN_ENABLE;

	wire [7:0] flags_rd = 8'(conversion_irq_flag) << BIT_CONV_FLAG;
	wire [7:0] enab_rd  = (8'(global_irq_enable) << BIT_GLOBAL_EN)
		| (8'(conversion_irq_enable) << BIT_CONV_IRQ_EN);
	wire [7:0] sclk_rd  = 8'(sample_divider_select) << BIT_DIV_SELECT;

	wire [7:0] rdata =
		(idx == IDX_IRQ_FLAGS)     ? flags_rd :
		(idx == IDX_IRQ_ENABLES)   ? enab_rd :
		(idx == IDX_RESULT_HIGH)   ? conversion_result[15:8] :
		(idx == IDX_RESULT_LOW)    ? conversion_result[7:0] :
		(idx == IDX_CONV_CTRL)     ? converter_control :
		(idx == IDX_SAMPLE_CLOCK)  ? sclk_rd :
		(idx == IDX_INPUT_ROUTING) ? input_routing :
		(idx == IDX_REF_ROUTING)   ? reference_routing :
		(idx == IDX_GAIN_ENABLE)   ? gain_and_enable : RST_REG;

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req;
			if (req)
				WB_DAT_O <= {24'h00_0000, rdata};
		end
	end

	// Control registers.
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			input_routing         <= RST_REG;
			reference_routing     <= RST_REG;
			gain_and_enable       <= RST_REG;
			converter_control     <= RST_REG;
			sample_divider_select <= 1'b0;
			conversion_irq_enable <= 1'b0;
			global_irq_enable     <= 1'b0;
		end else begin
			if (wr_inrt)
				input_routing <= wd;
			if (wr_refrt)
				reference_routing <= wd & REF_ROUTING_MASK;
			if (wr_gain)
				gain_and_enable <= wd & GAIN_ENABLE_MASK;
			if (wr_ctrl)
				converter_control <= wd & CONV_CTRL_MASK;
			if (wr_sclk)
				sample_divider_select <= wd[BIT_DIV_SELECT];
			if (wr_enab) begin
				conversion_irq_enable <= wd[BIT_CONV_IRQ_EN];
				global_irq_enable     <= wd[BIT_GLOBAL_EN];
			end
		end
	end

	wire       mod_en     = gain_and_enable[BIT_MOD_ENABLE];
	wire       comb_run   = converter_control[BIT_COMB_RUN];
	wire [2:0] rate_code  = converter_control[2:0];

	// Analog switch controls come straight from the routing registers and the gain and enable register.
	assign ANALOG_CTRL.filter_input_select       = input_routing[5:3];             // RULE1
	assign ANALOG_CTRL.filter_enable             = input_routing[2];               // RULE2
	assign ANALOG_CTRL.positive_path_select      = input_routing[1:0];             // RULE3
	assign ANALOG_CTRL.negative_input_select     = input_routing[7:6];             // RULE4
	assign ANALOG_CTRL.input_gain_select         = gain_and_enable[3:2];           // RULE5
	assign ANALOG_CTRL.internal_reference_enable = gain_and_enable[BIT_REF_ENABLE]; // RULE6
	assign ANALOG_CTRL.positive_reference_select = reference_routing[1:0];         // RULE7
	assign ANALOG_CTRL.negative_reference_select = reference_routing[3:2];         // RULE8
	assign ANALOG_CTRL.modulator_enable          = mod_en;                         // RULE12
	// High shorts both converter inputs to the negative input; low reconnects them.
	assign ANALOG_CTRL.auto_zero                 = gain_and_enable[BIT_AUTO_ZERO]; // RULE17 RULE18

	// Sample clock divider.
	wire [5:0] div_len  = sample_divider_select ? DIV_SLOW : DIV_FAST; // RULE10
	wire       div_last = div_cnt == div_len - 6'h01;

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			div_cnt       <= 6'h00;
			SAMPLE_STROBE <= 1'b0;
		end else begin
			div_cnt       <= (div_last || div_cnt >= div_len) ? 6'h00 : div_cnt + 6'h01;
			SAMPLE_STROBE <= div_last & mod_en;
		end
	end

	// The modulator bit comes from the analog domain and is synchronised first.
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			mod_sync1 <= 1'b0;
			mod_sync2 <= 1'b0;
		end else begin
			mod_sync1 <= MODULATOR_BIT;
			mod_sync2 <= mod_sync1;
		end
	end

	// Comb decimator: counts ones over the current and previous windows.
	wire [2:0]  rate_shift = (rate_code > MAX_RATE_SHIFT) ? MAX_RATE_SHIFT : rate_code; // RULE9
	wire [13:0] win_len    = BASE_WINDOW << rate_shift;                                // RULE9
	wire        comb_on    = comb_run & mod_en;                                        // RULE13
	wire        take       = SAMPLE_STROBE & comb_on;
	wire        win_last   = samp_cnt == win_len - 14'h0001;
	wire        load       = take & win_last;                                          // RULE19
	wire [13:0] ones_now   = ones_cur + 14'(mod_sync2);                                // RULE15

	// Ones density over two windows maps linearly onto plus and minus full scale.
	wire [14:0] total   = 15'(ones_prev) + 15'(ones_now);                         // RULE16
	wire [21:0] prod    = 22'(total * SCALE_PER_ONE);
	wire [21:0] shifted = prod >> rate_shift;
	wire signed [22:0] raw     = $signed({1'b0, shifted}) - FULL_SCALE;
	wire signed [22:0] clipped = (raw > FULL_SCALE) ? FULL_SCALE :
		(raw < -FULL_SCALE) ? -FULL_SCALE : raw;                                   // RULE20
	wire [15:0] next_result = 16'(clipped);                                        // RULE14

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			samp_cnt          <= 14'h0000;
			ones_cur          <= 14'h0000;
			ones_prev         <= 14'h0000;
			conversion_result <= 16'h0000;
		end else if (!comb_on) begin
			samp_cnt  <= 14'h0000; // RULE23
			ones_cur  <= 14'h0000; // RULE23
			ones_prev <= 14'h0000; // RULE23
		end else if (load) begin
			samp_cnt          <= 14'h0000;
			ones_cur          <= 14'h0000;
			ones_prev         <= ones_now;
			conversion_result <= next_result; // RULE19
		end else if (take) begin
			samp_cnt <= (samp_cnt >= win_len) ? 14'h0000 : samp_cnt + 14'h0001;
			ones_cur <= ones_now;
		end
	end

	// Conversion flag: a new result wins over a clear in the same cycle.
	wire flag_clear = wr_flags & ~wd[BIT_CONV_FLAG];

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET)
			conversion_irq_flag <= 1'b0;
		else if (load)
			conversion_irq_flag <= 1'b1; // RULE22
		else if (flag_clear)
			conversion_irq_flag <= 1'b0;
	end

	assign CONVERSION_IRQ = conversion_irq_flag & conversion_irq_enable & global_irq_enable; // RULE11

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	sequence s_strobe_gap;
		(!SAMPLE_STROBE)[*8] ##1 (!SAMPLE_STROBE)[*8] ##1 (!SAMPLE_STROBE)[*8];
	endsequence

	sequence s_result_loaded;
		load ##1 conversion_irq_flag;
	endsequence

	AST_IRQ_GATE: assert property (CONVERSION_IRQ |-> conversion_irq_enable && global_irq_enable
		&& conversion_irq_flag) // RULE11
		else $error("Interrupt raised without both enables and flag.");

	AST_FLAG_SET: assert property (s_result_loaded |-> conversion_result == $past(next_result)) // RULE22
		else $error("Flag set without the new result loaded.");

	AST_FLAG_HOLD: assert property (conversion_irq_flag && !flag_clear |=> conversion_irq_flag) // RULE22
		else $error("Conversion flag dropped without a software clear.");

	AST_COMB_HELD: assert property (!comb_run |=> samp_cnt == 14'h0000 && ones_cur == 14'h0000) // RULE23
		else $error("Comb accumulators not held while comb run is clear.");

	AST_SATURATE: assert property ($signed(conversion_result) <= 16'sh3d09
		&& $signed(conversion_result) >= -16'sh3d09) // RULE20
		else $error("Result beyond full scale.");

	AST_SIGN_BITS: assert property (conversion_result[15] == conversion_result[14]) // RULE14
		else $error("Top result bits disagree on sign.");

	AST_STROBE_GAP: assert property (SAMPLE_STROBE && $stable(div_len) |=> s_strobe_gap) // RULE10
		else $error("Sample strobes closer than the divisor allows.");

	AST_MOD_WRITE: assert property (wr_gain |=> ANALOG_CTRL.modulator_enable == $past(wd[1])) // RULE12
		else $error("Modulator enable did not follow the register write.");

	AST_AZ_WRITE: assert property (wr_gain |=> ANALOG_CTRL.auto_zero == $past(wd[0])) // RULE17 RULE18
		else $error("Auto-zero did not follow the register write.");

	AST_LOAD_WINDOW: assert property (load |-> samp_cnt == win_len - 14'h0001 && SAMPLE_STROBE) // RULE19
		else $error("Result loaded away from the end of a window.");

	AST_WB_ACK: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("Bus acknowledge not a single cycle after the request.");

	AST_ACK_CAUSE: assert property (WB_ACK_O
		|-> $past(req))
		else $error("Bus acknowledge without a request.");

	AST_RD_UPPER: assert property (WB_ACK_O
		|-> WB_DAT_O[31:8] == 24'h000000)
		else $error("Read data upper bytes not zero.");

	AST_FILT_SEL: assert property (wr_inrt // RULE1
		|=> ANALOG_CTRL.filter_input_select == $past(wd[5:3]))
		else $error("Filter input select did not follow the write.");

	AST_FILT_EN: assert property (wr_inrt // RULE2
		|=> ANALOG_CTRL.filter_enable == $past(wd[2]))
		else $error("Filter enable did not follow the write.");

	AST_POS_PATH: assert property (wr_inrt // RULE3
		|=> ANALOG_CTRL.positive_path_select == $past(wd[1:0]))
		else $error("Positive path select did not follow the write.");

	AST_NEG_IN: assert property (wr_inrt // RULE4
		|=> ANALOG_CTRL.negative_input_select == $past(wd[7:6]))
		else $error("Negative input select did not follow the write.");

	AST_GAIN_SEL: assert property (wr_gain // RULE5
		|=> ANALOG_CTRL.input_gain_select == $past(wd[3:2]))
		else $error("Gain select did not follow the write.");

	AST_REF_EN: assert property (wr_gain // RULE6
		|=> ANALOG_CTRL.internal_reference_enable == $past(wd[7]))
		else $error("Reference enable did not follow the write.");

	AST_POS_REF: assert property (wr_refrt // RULE7
		|=> ANALOG_CTRL.positive_reference_select == $past(wd[1:0]))
		else $error("Positive reference select did not follow the write.");

	AST_NEG_REF: assert property (wr_refrt // RULE8
		|=> ANALOG_CTRL.negative_reference_select == $past(wd[3:2]))
		else $error("Negative reference select did not follow the write.");

	AST_ROUTE_HOLD: assert property (!wr_inrt // RULE1 RULE2 RULE3 RULE4
		|=> $stable(input_routing))
		else $error("Input routing changed without a write.");

	AST_GAIN_HOLD: assert property (!wr_gain // RULE5 RULE6 RULE12 RULE17
		|=> $stable(gain_and_enable))
		else $error("Gain and enable register changed without a write.");

	AST_REF_HOLD: assert property (!wr_refrt // RULE7 RULE8
		|=> $stable(reference_routing))
		else $error("Reference routing changed without a write.");

	AST_RATE_TOP: assert property (rate_code == 3'h7 // RULE9
		|-> win_len == BASE_WINDOW << MAX_RATE_SHIFT)
		else $error("Top rate code does not use the longest window.");

	AST_RATE_WIN: assert property (rate_code < 3'h7 // RULE9
		|-> win_len == BASE_WINDOW << rate_code)
		else $error("Window length does not follow the rate code.");

	AST_DIV_WRAP: assert property (div_cnt >= div_len // RULE10
		|=> div_cnt == 6'h00)
		else $error("Divider count not restarted after a divisor change.");

	AST_STROBE_OFF: assert property (!mod_en // RULE12
		|=> !SAMPLE_STROBE)
		else $error("Sample strobe while the modulator is off.");

	AST_COMB_STOP: assert property (!comb_run // RULE13 RULE23
		|=> $stable(conversion_result))
		else $error("Result changed while the comb filter is stopped.");

	AST_MOD_SYNC: assert property (1'b1 // RULE15
		|-> mod_sync2 == $past(mod_sync1))
		else $error("Modulator bit not passed through the second stage.");

	AST_ONES_STEP: assert property (take && !load // RULE15
		|=> ones_cur == $past(ones_cur) + 14'($past(mod_sync2)))
		else $error("Ones count did not add the sampled bit.");

	AST_PREV_WIN: assert property (load // RULE16 RULE19
		|=> ones_prev == $past(ones_now))
		else $error("Previous window count not kept at a load.");

	sequence s_window_clear;
		samp_cnt == 14'h0000 && ones_cur == 14'h0000;
	endsequence

	AST_WIN_RESTART: assert property (load // RULE19
		|=> s_window_clear)
		else $error("Window counters not restarted after a load.");

	AST_SAT_POS: assert property (raw > FULL_SCALE // RULE20
		|-> clipped == FULL_SCALE)
		else $error("Positive overrange not clipped.");

	AST_SAT_NEG: assert property (raw < -FULL_SCALE // RULE20
		|-> clipped == -FULL_SCALE)
		else $error("Negative overrange not clipped.");

	AST_FLAG_WINS: assert property (load // RULE22
		|=> conversion_irq_flag)
		else $error("Conversion flag not set by a load.");

	AST_FLAG_CLEAR: assert property (flag_clear && !load // RULE22
		|=> !conversion_irq_flag)
		else $error("Conversion flag not cleared by software.");

	AST_IRQ_ON: assert property (conversion_irq_flag && conversion_irq_enable // RULE11
		&& global_irq_enable |-> CONVERSION_IRQ)
		else $error("Interrupt missing with flag and both enables set.");
endmodule : sdc_adc_ctrl

// *** pkg/sdc_pkg.sv ***
// Register map, field positions, reset values and analog control carrier of the converter block.
package sdc_pkg;
	// Register indexes; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h06;
	localparam logic [5:0] IDX_IRQ_ENABLES   = 6'h07;
	localparam logic [5:0] IDX_RESULT_HIGH   = 6'h10;
	localparam logic [5:0] IDX_RESULT_LOW    = 6'h11;
	localparam logic [5:0] IDX_CONV_CTRL     = 6'h13;
	localparam logic [5:0] IDX_SAMPLE_CLOCK  = 6'h14;
	localparam logic [5:0] IDX_INPUT_ROUTING = 6'h18;
	localparam logic [5:0] IDX_REF_ROUTING   = 6'h19;
	localparam logic [5:0] IDX_GAIN_ENABLE   = 6'h1a;

	localparam int BIT_CONV_FLAG   = 2;
	localparam int BIT_CONV_IRQ_EN = 2;
	localparam int BIT_GLOBAL_EN   = 7;
	localparam int BIT_COMB_RUN    = 3;
	localparam int BIT_DIV_SELECT  = 1;
	localparam int BIT_REF_ENABLE  = 7;
	localparam int BIT_MOD_ENABLE  = 1;
	localparam int BIT_AUTO_ZERO   = 0;

	localparam logic [7:0] RST_REG          = 8'h00;
	localparam logic [7:0] GAIN_ENABLE_MASK = 8'h8f;
	localparam logic [7:0] REF_ROUTING_MASK = 8'h0f;
	localparam logic [7:0] CONV_CTRL_MASK   = 8'h0f;

	// Sample clock divisors of the system clock.
	localparam logic [5:0] DIV_FAST = 6'h19;
	localparam logic [5:0] DIV_SLOW = 6'h32;

	// Shortest decimation window and the largest power of two applied to it.
	localparam logic [13:0] BASE_WINDOW    = 14'h007d;
	localparam logic [2:0]  MAX_RATE_SHIFT = 3'h6;

	// Result counts per one in the shortest window, and the saturation level.
	localparam logic [6:0]         SCALE_PER_ONE = 7'h7d;
	localparam logic signed [22:0] FULL_SCALE    = 23'sh003d09;

	typedef struct packed {
		logic [2:0] filter_input_select;
		logic       filter_enable;
		logic [1:0] positive_path_select;
		logic [1:0] negative_input_select;
		logic [1:0] input_gain_select;
		logic       internal_reference_enable;
		logic [1:0] positive_reference_select;
		logic [1:0] negative_reference_select;
		logic       modulator_enable;
		logic       auto_zero;
	} sdc_ana_ctrl_s;
endpackage : sdc_pkg

// *** tb/sdc_adc_ctrl_tb_top.sv ***
// Self-checking bench for the converter control block with a modulator model.
`timescale 1ns/100ps
module sdc_adc_ctrl_tb_top
	import sdc_pkg::*;
;
	logic          ref_clk = 1'b0;
	logic          reset   = 1'b1;
	logic          cyc     = 1'b0;
	logic          stb     = 1'b0;
	logic          we      = 1'b0;
	logic [7:0]    adr     = 8'h00;
	logic [7:0]    dens    = 8'h00;
	logic [7:0]    q, a, b, c;
	logic [3:0]    sel     = 4'h0;
	logic [31:0]   dat     = 32'h00000000;
	logic [31:0]   lfsr    = 32'h00016fa9;
	logic [31:0]   rdat;
	logic          ack, strobe, irq, mbit;
	sdc_ana_ctrl_s ana;
	int            n_mismatch = 0;
	int            cmp_count  = 0;
	int            cycles     = 0;
	int            nstb       = 0;
	int            t0;
	int            snap [3];
	logic [7:0]    addrs [10] = '{8'h18, 8'h1c, 8'h40, 8'h44, 8'h4c, 8'h50, 8'h60, 8'h64,
		8'h68, 8'h80};

	sdc_adc_ctrl dut (.REF_CLK(ref_clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .MODULATOR_BIT(mbit), .SAMPLE_STROBE(strobe), .ANALOG_CTRL(ana),
		.CONVERSION_IRQ(irq));
	sdc_mod_model model (.clk(ref_clk), .rst(reset), .strobe(strobe), .ctrl(ana),
		.density(dens), .bit_out(mbit));

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (strobe === 1'b1)
			nstb++;
		if (cycles > 90000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [31:0] nx(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nx

	function automatic sdc_ana_ctrl_s exp_ana(logic [7:0] p, logic [7:0] r, logic [7:0] g);
		return {p[5:3], p[2], p[1:0], p[7:6], g[3:2], g[7], r[1:0], r[3:2], g[1], g[0]};
	endfunction : exp_ana

	function automatic logic [15:0] exp_res(int d);
		int v;
		v = d * 125 - 15625;
		if (v > 15625)
			v = 15625;
		if (v < -15625)
			v = -15625;
		return v[15:0];
	endfunction : exp_res

	// One classic Wishbone cycle; the request stands until ack is seen high.
	task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= ad;
		sel <= s;
		dat <= {24'h000000, d};
		do @(posedge ref_clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic per(input int e);
		int n;
		n = 0;
		while (strobe !== 1'b1) @(posedge ref_clk);
		do begin
			@(posedge ref_clk);
			n++;
		end while (strobe !== 1'b1);
		check(17'(n), 17'(e));
	endtask : per

	task automatic conv(input logic [2:0] r, input logic [7:0] d, input logic az);
		logic [15:0] res;
		dens <= d;
		wb(1'b1, 8'h68, {6'h00, 1'b1, az}, 4'h1);
		wb(1'b1, 8'h1c, 8'h84, 4'h1);
		wb(1'b1, 8'h4c, {5'h01, r}, 4'h1);
		for (int n = 0; n < 3; n++) begin
			while (irq !== 1'b1) @(posedge ref_clk);
			snap[n] = nstb;
			wb(1'b0, 8'h40, 8'h00, 4'hf);
			res[15:8] = q;
			wb(1'b0, 8'h44, 8'h00, 4'hf);
			res[7:0] = q;
			wb(1'b1, 8'h18, 8'h00, 4'h1);
		end
		check(res, exp_res(az ? 125 : d));
		check(17'(snap[2] - snap[1]), 17'(125 << r));
		wb(1'b1, 8'h4c, 8'h00, 4'h1);
	endtask : conv

	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (addrs[i]) begin
			wb(1'b0, addrs[i], 8'h00, 4'hf);
			check(q, 17'h0);
		end
		for (int i = 0; i < 8; i++) begin
			lfsr = nx(lfsr);
			a = {i[1:0], i[2:0], i[2:0]};
			b = {lfsr[15:12], i[1:0], i[1:0]};
			c = {lfsr[7], 3'h0, i[1:0], 1'b0, lfsr[0]};
			wb(1'b1, 8'h60, a, lfsr[11:8] | 4'h1);
			wb(1'b1, 8'h64, b, 4'h1);
			wb(1'b1, 8'h68, c, 4'h1);
			#1 check(ana, exp_ana(a, b, c));
			wb(1'b0, 8'h64, 8'h00, 4'hf);
			check(q, {13'h0, b[3:0]});
		end
		wb(1'b1, 8'h60, 8'h00, 4'he);
		wb(1'b0, 8'h60, 8'h00, 4'hf);
		check(q, 17'hff);
		wb(1'b1, 8'h68, 8'h02, 4'h1);
		per(25);
		wb(1'b1, 8'h50, 8'h02, 4'h1);
		per(50);
		wb(1'b1, 8'h50, 8'h00, 4'h1);
		wb(1'b1, 8'h68, 8'h00, 4'h1);
		t0 = nstb;
		repeat (60) @(posedge ref_clk);
		check(17'(nstb - t0), 17'h0);
		conv(3'h0, 8'hc8, 1'b0);
		wb(1'b1, 8'h4c, 8'h08, 4'h1);
		wb(1'b1, 8'h1c, 8'h04, 4'h1);
		repeat (3300) @(posedge ref_clk);
		check(irq, 17'h0);
		wb(1'b0, 8'h18, 8'h00, 4'hf);
		check(q, 17'h04);
		wb(1'b1, 8'h1c, 8'h84, 4'h1);
		#1 check(irq, 17'h1);
		wb(1'b1, 8'h4c, 8'h00, 4'h1);
		wb(1'b1, 8'h18, 8'h00, 4'h1);
		repeat (3300) @(posedge ref_clk);
		wb(1'b0, 8'h18, 8'h00, 4'hf);
		check(q, 17'h0);
		conv(3'h1, 8'h28, 1'b1);
		conv(3'h0, 8'h00, 1'b0);
		conv(3'h0, 8'hfa, 1'b0);
		summarize();
	end
endmodule : sdc_adc_ctrl_tb_top

// *** tb/sdc_mod_model.sv ***
// Behavioural modulator that turns a count of ones per 250 samples into a bitstream.
`timescale 1ns/100ps
module sdc_mod_model
	import sdc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          strobe,
	input  wire sdc_ana_ctrl_s ctrl,
	input  wire logic [7:0]    density,
	output logic               bit_out
);
	logic [8:0] acc;
	// Shorted inputs give the mid-scale density that an offset-free converter produces.
	wire logic [7:0] step = ctrl.auto_zero ? 8'h7d : density;
	wire logic [8:0] sum  = acc + {1'b0, step};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc     <= 9'h000;
			bit_out <= 1'b0;
		end else if (!ctrl.modulator_enable) begin
			acc     <= 9'h000;
			bit_out <= 1'b0;
		end else if (strobe) begin
			bit_out <= (sum >= 9'h0fa);
			acc     <= (sum >= 9'h0fa) ? sum - 9'h0fa : sum;
		end
	end
endmodule : sdc_mod_model
